// >>> core/jac_jog_axis.sv
/*
  Jog controller for one positioning axis with Avalon-MM register slave,
  step/direction drive output and limit switch inputs.
  Assumes limit switches are asynchronous, active low (open = limit hit),
  and that the drive takes one step per step_pulse_o cycle.
*/
// What this block does
// - Jog start rising edge accelerates axis in set direction; busy set.
// - At jog speed, hold that speed while jog start stays high.
// - Jog start low decelerates from jog speed over deceleration time.
// - Speed falling to bias in deceleration stops the axis and clears busy.
// - Stop command during jog decelerates the axis to a stop.
// - Jog start rising with stop held: no motion, error 1102.
// - After stop released, jogging resumes only on a new start edge.
// - Start re-raised during deceleration is ignored.
// - Jog speed above speed limit runs at limit with warning 1020.
// - Jog speed below bias runs at bias with warning 1020.
// - Bias and jog speed zero: speed-zero flag, axis still, status 2, busy.
// - Nonzero speed change in zero state clears flag and jogs on.
// - Speed changed to zero with nonzero bias: warning, runs at bias.
// - Speed changes during deceleration are rejected.
// - Jog start is ignored while busy; reversal needs busy clear first.
// - Speed change command applies a new jog speed while jogging.
// - Enabled hardware limit input in moving direction decelerates to stop.
// - Software limits refuse outward starts and stop motion leaving range.
`timescale 1ns/10ps
module jac_jog_axis #(
  parameter int unsigned SPD_W = jac_pkg::SPD_W_DEF
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        limit_upper_n_i,
  input  wire logic        limit_lower_n_i,
  output logic             step_pulse_o,
  output logic             step_dir_o,
  output logic             axis_busy_o
);
  // Speeds above 25 bits could exceed CLK_HZ, needing more than one step per clock
  if (SPD_W < 4 || SPD_W > 25) begin : g_bad_spd_w
    $error("SPD_W out of range");
  end

  jac_ramp_if #(.SPD_W(SPD_W)) rif ();
  jac_ramp u_ramp (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .rif(rif));

  jac_pkg::jac_state_t state_r;
  jac_pkg::jac_state_t state_nxt;
  logic [6:0]       ctrl_r;
  logic [SPD_W-1:0] jog_spd_r;
  logic [SPD_W-1:0] spd_lim_r;
  logic [SPD_W-1:0] bias_r;
  logic [SPD_W-1:0] new_spd_r;
  logic [SPD_W-1:0] run_spd_r;
  logic [SPD_W-1:0] run_spd_nxt;
  logic [15:0]      acc_r;
  logic [15:0]      dec_r;
  logic [31:0]      sw_up_r;
  logic [31:0]      sw_lo_r;
  logic [31:0]      pos_r;
  logic [31:0]      phase_r;
  logic [15:0]      err_r;
  logic [15:0]      err_nxt;
  logic [15:0]      wrn_r;
  logic             wrn_set;
  logic             spd_zero_r;
  logic             jog_prev_r;
  logic [1:0]       lim_up_sync_r;
  logic [1:0]       lim_lo_sync_r;
  logic [7:0]       tick_cnt_r;
  logic             tick_r;
  logic             move_rev_r;
  logic             load;
  logic [SPD_W-1:0] load_val;

  wire acc_go  = avs_write_i && !avs_waitrequest_o;
  wire jog_cmd = ctrl_r[jac_pkg::B_JOG];
  wire stop    = ctrl_r[jac_pkg::B_STOP];
  wire jog_rise = jog_cmd && !jog_prev_r;
  wire err_rst = acc_go && avs_address_i == jac_pkg::A_CTRL
                 && avs_writedata_i[jac_pkg::B_ERRRST];
  wire spd_chg = acc_go && avs_address_i == jac_pkg::A_CTRL
                 && avs_writedata_i[jac_pkg::B_SPDCHG];
  wire hit_up = ctrl_r[jac_pkg::B_HWEN] && !lim_up_sync_r[1];
  wire hit_lo = ctrl_r[jac_pkg::B_HWEN] && !lim_lo_sync_r[1];
  wire sw_up  = ctrl_r[jac_pkg::B_SWEN] && $signed(pos_r) >= $signed(sw_up_r);
  wire sw_lo  = ctrl_r[jac_pkg::B_SWEN] && $signed(pos_r) <= $signed(sw_lo_r);

  function automatic logic [SPD_W-1:0] clamp(input logic [SPD_W-1:0] v,
      input logic [SPD_W-1:0] lim, input logic [SPD_W-1:0] bias);
    clamp = (v > lim) ? lim : ((v < bias) ? bias : v);
  endfunction : clamp

  // Limit switches come straight from the machine
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      lim_up_sync_r <= 2'h3;
      lim_lo_sync_r <= 2'h3;
    end else begin
      lim_up_sync_r <= {lim_up_sync_r[0], limit_upper_n_i};
      lim_lo_sync_r <= {lim_lo_sync_r[0], limit_lower_n_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tick_cnt_r <= 8'h00;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= tick_cnt_r == 8'(jac_pkg::TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == 8'(jac_pkg::TICK_CYC - 1))
                    ? 8'h00 : tick_cnt_r + 8'h01;
    end
  end

  always_comb begin
    logic [SPD_W-1:0] c;
    logic             hit_dir;
    logic             sw_dir;
    c           = clamp(jog_spd_r, spd_lim_r, bias_r);
    hit_dir     = move_rev_r ? hit_lo : hit_up;
    sw_dir      = move_rev_r ? sw_lo : sw_up;
    state_nxt   = state_r;
    run_spd_nxt = run_spd_r;
    err_nxt     = jac_pkg::ERR_NONE;
    wrn_set     = 1'b0;
    load        = 1'b0;
    load_val    = '0;
    case (state_r)
      jac_pkg::ST_IDLE: begin
        // Level-held start is not a start: only its edge counts
        if (jog_rise && err_r == jac_pkg::ERR_NONE) begin
          if (stop) begin
            err_nxt = jac_pkg::ERR_STOP_ON;
          end else if (!ctrl_r[jac_pkg::B_REV] && hit_up) begin
            err_nxt = jac_pkg::ERR_HW_UP;
          end else if (ctrl_r[jac_pkg::B_REV] && hit_lo) begin
            err_nxt = jac_pkg::ERR_HW_LO;
          end else if (!ctrl_r[jac_pkg::B_REV] && sw_up) begin
            err_nxt = jac_pkg::ERR_SW_UP;
          end else if (ctrl_r[jac_pkg::B_REV] && sw_lo) begin
            err_nxt = jac_pkg::ERR_SW_LO;
          end else begin
            run_spd_nxt = c;
            wrn_set     = c != jog_spd_r;
            load        = 1'b1;
            load_val    = bias_r;
            state_nxt   = (c == '0) ? jac_pkg::ST_ZERO
                                    : jac_pkg::ST_RUN;
          end
        end
      end
      jac_pkg::ST_RUN, jac_pkg::ST_ZERO: begin
        if (spd_chg) begin
          run_spd_nxt = clamp(new_spd_r, spd_lim_r, bias_r);
          wrn_set     = run_spd_nxt != new_spd_r;
          if (state_r == jac_pkg::ST_ZERO && run_spd_nxt != '0) begin
            state_nxt = jac_pkg::ST_RUN;
            load      = 1'b1;
            load_val  = bias_r;
          end else if (run_spd_nxt == '0) begin
            state_nxt = jac_pkg::ST_ZERO;
            load      = 1'b1;
          end
        end
        if (hit_dir) begin
          err_nxt = move_rev_r ? jac_pkg::ERR_HW_LO
                               : jac_pkg::ERR_HW_UP;
        end else if (sw_dir) begin
          err_nxt = move_rev_r ? jac_pkg::ERR_SW_LO
                               : jac_pkg::ERR_SW_UP;
        end
        if (!jog_cmd || stop || hit_dir || sw_dir) begin
          state_nxt = (state_r == jac_pkg::ST_ZERO) ? jac_pkg::ST_IDLE
                                                    : jac_pkg::ST_DECEL;
          load      = state_r == jac_pkg::ST_ZERO;
        end
      end
      jac_pkg::ST_DECEL: begin
        // Start edges and speed changes fall through unheard here
        if (rif.speed <= bias_r) begin
          state_nxt = jac_pkg::ST_IDLE;
          load      = 1'b1;
        end
      end
      default: begin
        state_nxt = jac_pkg::ST_IDLE;
      end
    endcase
  end

  assign rif.load     = load;
  assign rif.load_val = load_val;
  assign rif.target   = (state_r == jac_pkg::ST_RUN) ? run_spd_r : '0;
  assign rif.rate     = (state_r == jac_pkg::ST_RUN) ? acc_r : dec_r;
  assign rif.tick     = tick_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_r     <= jac_pkg::ST_IDLE;
      run_spd_r   <= '0;
      spd_zero_r  <= 1'b0;
      axis_busy_o <= 1'b0;
      jog_prev_r  <= 1'b0;
      move_rev_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      run_spd_r   <= run_spd_nxt;
      spd_zero_r  <= state_nxt == jac_pkg::ST_ZERO;
      axis_busy_o <= state_nxt != jac_pkg::ST_IDLE;
      jog_prev_r  <= jog_cmd;
      if (state_r == jac_pkg::ST_IDLE) begin
        move_rev_r <= ctrl_r[jac_pkg::B_REV];
      end
    end
  end

  // A new code landing with the reset wins, so nothing is lost
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      err_r <= jac_pkg::ERR_NONE;
      wrn_r <= jac_pkg::ERR_NONE;
    end else begin
      if (err_nxt != jac_pkg::ERR_NONE && (err_r == jac_pkg::ERR_NONE
          || err_rst)) begin
        err_r <= err_nxt;
      end else if (err_rst) begin
        err_r <= jac_pkg::ERR_NONE;
      end
      if (wrn_set) begin
        wrn_r <= jac_pkg::WRN_SPD_RNG;
      end else if (err_rst) begin
        wrn_r <= jac_pkg::ERR_NONE;
      end
    end
  end

  // Step generator: phase accumulates speed in steps per second
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      phase_r      <= 32'h0000_0000;
      pos_r        <= 32'h0000_0000;
      step_pulse_o <= 1'b0;
      step_dir_o   <= 1'b0;
    end else begin
      step_dir_o   <= move_rev_r;
      step_pulse_o <= 1'b0;
      if (phase_r + 32'(rif.speed) >= jac_pkg::CLK_HZ) begin
        phase_r      <= phase_r + 32'(rif.speed) - jac_pkg::CLK_HZ;
        step_pulse_o <= 1'b1;
        pos_r        <= move_rev_r ? pos_r - 32'h1 : pos_r + 32'h1;
      end else begin
        phase_r <= phase_r + 32'(rif.speed);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctrl_r    <= 7'h00;
      jog_spd_r <= '0;
      spd_lim_r <= '1;
      bias_r    <= '0;
      new_spd_r <= '0;
      acc_r     <= jac_pkg::RATE_RST;
      dec_r     <= jac_pkg::RATE_RST;
      sw_up_r   <= jac_pkg::SWUP_RST;
      sw_lo_r   <= jac_pkg::SWLO_RST;
    end else if (acc_go) begin
      case (avs_address_i)
        jac_pkg::A_CTRL: begin
          ctrl_r <= {2'b00, avs_writedata_i[4:0]};
        end
        jac_pkg::A_JOGSPD: jog_spd_r <= avs_writedata_i[SPD_W-1:0];
        jac_pkg::A_SPDLIM: spd_lim_r <= avs_writedata_i[SPD_W-1:0];
        jac_pkg::A_BIAS:   bias_r    <= avs_writedata_i[SPD_W-1:0];
        jac_pkg::A_ACC:    acc_r     <= avs_writedata_i[15:0];
        jac_pkg::A_DEC:    dec_r     <= avs_writedata_i[15:0];
        jac_pkg::A_NEWSPD: new_spd_r <= avs_writedata_i[SPD_W-1:0];
        jac_pkg::A_SWUP:   sw_up_r   <= avs_writedata_i;
        jac_pkg::A_SWLO:   sw_lo_r   <= avs_writedata_i;
        default: begin
        end
      endcase
    end
  end

  // Fixed one-wait-state slave; unmapped reads return zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        case (avs_address_i)
          jac_pkg::A_CTRL:   avs_readdata_o <= {25'h0, ctrl_r};
          jac_pkg::A_JOGSPD: avs_readdata_o <= 32'(jog_spd_r);
          jac_pkg::A_SPDLIM: avs_readdata_o <= 32'(spd_lim_r);
          jac_pkg::A_BIAS:   avs_readdata_o <= 32'(bias_r);
          jac_pkg::A_ACC:    avs_readdata_o <= {16'h0, acc_r};
          jac_pkg::A_DEC:    avs_readdata_o <= {16'h0, dec_r};
          jac_pkg::A_NEWSPD: avs_readdata_o <= 32'(new_spd_r);
          jac_pkg::A_SWUP:   avs_readdata_o <= sw_up_r;
          jac_pkg::A_SWLO:   avs_readdata_o <= sw_lo_r;
          jac_pkg::A_POS:    avs_readdata_o <= pos_r;
          jac_pkg::A_STAT: begin
            avs_readdata_o <= {16'h0, axis_busy_o ? jac_pkg::OPST_JOG
                               : jac_pkg::OPST_IDLE, 5'h0, move_rev_r,
                               spd_zero_r, axis_busy_o};
          end
          jac_pkg::A_CODES:  avs_readdata_o <= {wrn_r, err_r};
          jac_pkg::A_CURSPD: avs_readdata_o <= 32'(rif.speed);
          default:           avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  property p_start;
    state_r == jac_pkg::ST_IDLE && jog_rise && !stop
      && err_r == jac_pkg::ERR_NONE && err_nxt == jac_pkg::ERR_NONE
      |=> axis_busy_o && rif.speed == bias_r;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop_err;
    state_r == jac_pkg::ST_IDLE && jog_rise && stop
      && err_r == jac_pkg::ERR_NONE
      |=> err_r == jac_pkg::ERR_STOP_ON && !axis_busy_o;
  endproperty
  a_stop_err: assert property (p_stop_err) else $error("no 1102");

  property p_hold;
    state_r == jac_pkg::ST_RUN && rif.speed == run_spd_r && state_nxt
      == jac_pkg::ST_RUN && !load && !spd_chg |=> rif.speed == $past(run_spd_r);
  endproperty
  a_hold: assert property (p_hold) else $error("speed drifted");

  property p_decel;
    state_r == jac_pkg::ST_RUN && (!jog_cmd || stop)
      |=> state_r == jac_pkg::ST_DECEL ##1 rif.target == '0;
  endproperty
  a_decel: assert property (p_decel) else $error("no deceleration");

  property p_end;
    state_r == jac_pkg::ST_DECEL && rif.speed <= bias_r
      |=> !axis_busy_o && rif.speed == '0;
  endproperty
  a_end: assert property (p_end) else $error("stop not reached");

  property p_no_resume;
    state_r == jac_pkg::ST_DECEL |=> state_r != jac_pkg::ST_RUN
      && $stable(run_spd_r);
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("resumed");

  property p_clamp;
    state_r == jac_pkg::ST_RUN |-> run_spd_r <= spd_lim_r;
  endproperty
  a_clamp: assert property (p_clamp) else $error("over speed limit");

  property p_zero;
    state_r == jac_pkg::ST_ZERO |-> spd_zero_r && axis_busy_o
      && rif.target == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero state wrong");

  property p_err_hold;
    err_r != jac_pkg::ERR_NONE && !err_rst |=> $stable(err_r);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost");

  property p_bus;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");

  c_run: cover property (state_r == jac_pkg::ST_RUN
                         && rif.speed == run_spd_r);
  c_done: cover property (state_r == jac_pkg::ST_DECEL
                          ##1 state_r == jac_pkg::ST_IDLE);
  c_zero: cover property (state_r == jac_pkg::ST_ZERO);
  c_err: cover property (err_r == jac_pkg::ERR_STOP_ON);
endmodule : jac_jog_axis

// >>> core/jac_pkg.sv
/*
  Shared constants of the jog axis controller: register map, control
  bit positions, error and warning codes, operation status, timing.
  Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package jac_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned CLK_PER_NS  = 20;
  localparam int unsigned TICK_NS     = 1000;
  localparam int unsigned TICK_CYC    = (TICK_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned SPD_W_DEF   = 20;

  localparam logic [5:0] A_CTRL   = 6'h00;
  localparam logic [5:0] A_JOGSPD = 6'h04;
  localparam logic [5:0] A_SPDLIM = 6'h08;
  localparam logic [5:0] A_BIAS   = 6'h0c;
  localparam logic [5:0] A_ACC    = 6'h10;
  localparam logic [5:0] A_DEC    = 6'h14;
  localparam logic [5:0] A_NEWSPD = 6'h18;
  localparam logic [5:0] A_SWUP   = 6'h1c;
  localparam logic [5:0] A_SWLO   = 6'h20;
  localparam logic [5:0] A_POS    = 6'h24;
  localparam logic [5:0] A_STAT   = 6'h28;
  localparam logic [5:0] A_CODES  = 6'h2c;
  localparam logic [5:0] A_CURSPD = 6'h30;

  localparam int unsigned B_JOG    = 0;
  localparam int unsigned B_STOP   = 1;
  localparam int unsigned B_REV    = 2;
  localparam int unsigned B_HWEN   = 3;
  localparam int unsigned B_SWEN   = 4;
  localparam int unsigned B_ERRRST = 5;
  localparam int unsigned B_SPDCHG = 6;

  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_HW_UP   = 16'h044c;
  localparam logic [15:0] ERR_HW_LO   = 16'h044d;
  localparam logic [15:0] ERR_STOP_ON = 16'h044e;
  localparam logic [15:0] ERR_SW_UP   = 16'h044f;
  localparam logic [15:0] ERR_SW_LO   = 16'h0450;
  localparam logic [15:0] WRN_SPD_RNG = 16'h03fc;
  localparam logic [7:0]  OPST_IDLE   = 8'h00;
  localparam logic [7:0]  OPST_JOG    = 8'h02;
  localparam logic [31:0] SWUP_RST    = 32'h7fff_ffff;
  localparam logic [31:0] SWLO_RST    = 32'h8000_0000;
  localparam logic [15:0] RATE_RST    = 16'h0001;

  typedef enum logic [1:0] {
    ST_IDLE, ST_RUN, ST_ZERO, ST_DECEL
  } jac_state_t;
endpackage : jac_pkg

// >>> core/jac_ramp.sv
/*
  Linear speed ramp: one speed unit per 'rate' ticks toward the target.
  Assumes a one-cycle tick enable and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module jac_ramp (
  input  wire logic  ref_clk_i,
  input  wire logic  srst_i,
  jac_ramp_if.ramp   rif
);
  logic [15:0] cnt_r;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_r <= 16'h0000;
    end else if (rif.load || rif.speed == rif.target) begin
      cnt_r <= 16'h0000;
    end else if (rif.tick) begin
      cnt_r <= (cnt_r + 16'h0001 >= rif.rate) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end

  // A rate of zero still steps once per tick, never jumps
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rif.speed <= '0;
    end else if (rif.load) begin
      rif.speed <= rif.load_val;
    end else if (rif.tick && (cnt_r + 16'h0001 >= rif.rate)) begin
      if (rif.speed < rif.target) begin
        rif.speed <= rif.speed + 1'b1;
      end else if (rif.speed > rif.target) begin
        rif.speed <= rif.speed - 1'b1;
      end
    end
  end
endmodule : jac_ramp

// >>> core/jac_ramp_if.sv
/*
  Link between the jog sequencer and the speed ramp.
  Assumes both ends share the system clock.
*/
`timescale 1ns/10ps
interface jac_ramp_if #(parameter int unsigned SPD_W = 20);
  logic             load;
  logic [SPD_W-1:0] load_val;
  logic [SPD_W-1:0] target;
  logic [15:0]      rate;
  logic             tick;
  logic [SPD_W-1:0] speed;
  modport ctrl (output load, load_val, target, rate, tick, input speed);
  modport ramp (input load, load_val, target, rate, tick, output speed);
endinterface : jac_ramp_if

// >>> testbench/jac_drive_model.sv
/*
  Behavioural model of the motor drive and the two limit switches.
  Assumes one step per step pulse; switches read low while hit.
*/
`timescale 1ns/10ps
module jac_drive_model (
  input  wire logic ref_clk_i,
  input  wire logic step_pulse_i,
  input  wire logic step_dir_i,
  input  wire logic hit_upper_i,
  input  wire logic hit_lower_i,
  output logic      limit_upper_n_o,
  output logic      limit_lower_n_o,
  output int        steps_o
);
  initial steps_o = 0;

  // Both switches are always wired, even when the limit check is off
  assign limit_upper_n_o = ~hit_upper_i;
  assign limit_lower_n_o = ~hit_lower_i;

  always @(posedge ref_clk_i) begin
    if (step_pulse_i === 1'b1) begin
      steps_o <= step_dir_i ? steps_o - 1 : steps_o + 1;
    end
  end
endmodule : jac_drive_model

// >>> testbench/tb_top.sv
/*
  Self-checking bench of the jog axis controller: Avalon-MM master,
  drive and limit switch model, read results checked from a queue.
  Assumes the design answers each access with one waitrequest-low cycle.
*/
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] B = 32'h0000c350;
  logic        ref_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, step_pulse_o, step_dir_o, axis_busy_o;
  logic        lim_up_n, lim_lo_n;
  logic        hit_up = 1'b0;
  logic        hit_lo = 1'b0;
  int          steps, fails = 0, num_checks = 0, cyc = 0;
  logic [31:0] exp_q[$], msk_q[$], r;

  always #10 ref_clk_i = ~ref_clk_i;

  jac_jog_axis dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .limit_upper_n_i(lim_up_n), .limit_lower_n_i(lim_lo_n),
    .step_pulse_o(step_pulse_o), .step_dir_o(step_dir_o),
    .axis_busy_o(axis_busy_o));

  jac_drive_model drv (.ref_clk_i(ref_clk_i), .step_pulse_i(step_pulse_o),
    .step_dir_i(step_dir_o), .hit_upper_i(hit_up), .hit_lower_i(hit_lo),
    .limit_upper_n_o(lim_up_n), .limit_lower_n_o(lim_lo_n),
    .steps_o(steps));

  task summarize;
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    num_checks++;
    if ((got & m) !== (e & m)) begin
      fails++;
      $display("ERROR %0t read %h expected %h", $time, got, e);
    end
  endtask : chk

  task chk_bit(input logic got, input logic e);
    num_checks++;
    if (got !== e) begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, got, e);
    end
  endtask : chk_bit

  // Read data counts only at the edge where waitrequest is sampled low
  always @(posedge ref_clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
      chk(avs_readdata_o, exp_q.pop_front(), msk_q.pop_front());
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Bounded wait for the busy flag, then compare it
  task wait_busy(input logic v, input int max);
    int n;
    n = 0;
    while (axis_busy_o !== v && n < max) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk_bit(axis_busy_o, v);
  endtask : wait_busy

  initial begin
    r = $urandom(73);
    r = 32'($urandom_range(40, 1));
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(jac_pkg::A_SPDLIM, 32'h000fffff, 32'h000fffff);
    rd(jac_pkg::A_ACC, 32'h00000001, 32'hffffffff);
    rd(jac_pkg::A_SWUP, jac_pkg::SWUP_RST, 32'hffffffff);
    rd(jac_pkg::A_SWLO, jac_pkg::SWLO_RST, 32'hffffffff);
    rd(6'h3c, 32'h0, 32'hffffffff);
    wr(jac_pkg::A_BIAS, B);
    wr(jac_pkg::A_JOGSPD, B + 32'h3);
    wr(jac_pkg::A_CTRL, 32'h1);
    wait_busy(1'b1, 10);
    rd(jac_pkg::A_STAT, 32'h00000201, 32'h0000ff07);
    repeat (300) @(posedge ref_clk_i);
    rd(jac_pkg::A_CURSPD, B + 32'h3, 32'h000fffff);
    repeat (1200) @(posedge ref_clk_i);
    chk_bit(steps > 0, 1'b1);
    wr(jac_pkg::A_CTRL, 32'h0);
    wait_busy(1'b0, 250);
    rd(jac_pkg::A_CURSPD, 32'h0, 32'h000fffff);
    wr(jac_pkg::A_SPDLIM, B + 32'h2);
    wr(jac_pkg::A_JOGSPD, B + 32'h3 + r);
    wr(jac_pkg::A_CTRL, 32'h1);
    repeat (250) @(posedge ref_clk_i);
    rd(jac_pkg::A_CURSPD, B + 32'h2, 32'h000fffff);
    rd(jac_pkg::A_CODES, {jac_pkg::WRN_SPD_RNG, 16'h0}, 32'hffff0000);
    wr(jac_pkg::A_CTRL, 32'h0);
    wait_busy(1'b0, 250);
    wr(jac_pkg::A_CTRL, 32'h20);
    rd(jac_pkg::A_CODES, 32'h0, 32'hffffffff);
    wr(jac_pkg::A_SPDLIM, 32'h000fffff);
    wr(jac_pkg::A_JOGSPD, B - r);
    wr(jac_pkg::A_CTRL, 32'h1);
    repeat (20) @(posedge ref_clk_i);
    rd(jac_pkg::A_CURSPD, B, 32'h000fffff);
    rd(jac_pkg::A_CODES, {jac_pkg::WRN_SPD_RNG, 16'h0}, 32'hffff0000);
    wr(jac_pkg::A_NEWSPD, B + 32'h2);
    wr(jac_pkg::A_CTRL, 32'h41);
    repeat (200) @(posedge ref_clk_i);
    rd(jac_pkg::A_CURSPD, B + 32'h2, 32'h000fffff);
    wr(jac_pkg::A_NEWSPD, 32'h0);
    wr(jac_pkg::A_CTRL, 32'h41);
    repeat (200) @(posedge ref_clk_i);
    rd(jac_pkg::A_CURSPD, B, 32'h000fffff);
    wr(jac_pkg::A_CTRL, 32'h3);
    wait_busy(1'b0, 250);
    wr(jac_pkg::A_CTRL, 32'h1);
    repeat (100) @(posedge ref_clk_i);
    chk_bit(axis_busy_o, 1'b0);
    wr(jac_pkg::A_CTRL, 32'h20);
    wr(jac_pkg::A_CTRL, 32'h2);
    wr(jac_pkg::A_CTRL, 32'h3);
    repeat (20) @(posedge ref_clk_i);
    chk_bit(axis_busy_o, 1'b0);
    rd(jac_pkg::A_CODES, 32'(jac_pkg::ERR_STOP_ON), 32'h0000ffff);
    wr(jac_pkg::A_CTRL, 32'h2);
    wr(jac_pkg::A_CTRL, 32'h0);
    wr(jac_pkg::A_CTRL, 32'h1);
    repeat (20) @(posedge ref_clk_i);
    chk_bit(axis_busy_o, 1'b0);
    // Recovery order: jog off, error reset, stop off, jog on
    wr(jac_pkg::A_CTRL, 32'h2);
    wr(jac_pkg::A_CTRL, 32'h22);
    wr(jac_pkg::A_CTRL, 32'h0);
    wr(jac_pkg::A_CTRL, 32'h1);
    wait_busy(1'b1, 10);
    wr(jac_pkg::A_DEC, 32'h4);
    wr(jac_pkg::A_NEWSPD, B + 32'h3);
    wr(jac_pkg::A_CTRL, 32'h41);
    repeat (300) @(posedge ref_clk_i);
    wr(jac_pkg::A_CTRL, 32'h0);
    wr(jac_pkg::A_NEWSPD, B + 32'h20);
    wr(jac_pkg::A_CTRL, 32'h41);
    wait_busy(1'b0, 800);
    repeat (50) @(posedge ref_clk_i);
    chk_bit(axis_busy_o, 1'b0);
    wr(jac_pkg::A_CTRL, 32'h0);
    wr(jac_pkg::A_CTRL, 32'h5);
    wait_busy(1'b1, 10);
    @(posedge ref_clk_i);
    chk_bit(step_dir_o, 1'b1);
    wr(jac_pkg::A_CTRL, 32'h0);
    wait_busy(1'b0, 800);
    wr(jac_pkg::A_BIAS, 32'h0);
    wr(jac_pkg::A_JOGSPD, 32'h0);
    wr(jac_pkg::A_CTRL, 32'h1);
    wait_busy(1'b1, 10);
    rd(jac_pkg::A_STAT, 32'h00000203, 32'h0000ff03);
    rd(jac_pkg::A_CURSPD, 32'h0, 32'h000fffff);
    wr(jac_pkg::A_NEWSPD, 32'h3);
    wr(jac_pkg::A_CTRL, 32'h41);
    repeat (5) @(posedge ref_clk_i);
    rd(jac_pkg::A_STAT, 32'h00000201, 32'h0000ff03);
    wr(jac_pkg::A_CTRL, 32'h0);
    wait_busy(1'b0, 800);
    wr(jac_pkg::A_BIAS, B);
    wr(jac_pkg::A_JOGSPD, B);
    // Upper switch on a forward run, then lower switch on a reverse run
    for (int i = 0; i < 2; i++) begin
      wr(jac_pkg::A_CTRL, i ? 32'h2d : 32'h29);
      wait_busy(1'b1, 10);
      hit_up <= (i == 0);
      hit_lo <= (i == 1);
      wait_busy(1'b0, 300);
      rd(jac_pkg::A_CODES, i ? 32'h044d : 32'h044c, 32'h0000ffff);
      hit_up <= 1'b0;
      hit_lo <= 1'b0;
      wr(jac_pkg::A_CTRL, 32'h20);
    end
    wr(jac_pkg::A_SWUP, 32'h80000000);
    wr(jac_pkg::A_CTRL, 32'h11);
    wait_busy(1'b0, 300);
    rd(jac_pkg::A_CODES, 32'(jac_pkg::ERR_SW_UP), 32'h0000ffff);
    summarize();
  end
endmodule : tb_top
